// File: design/scsc_pkg.sv
// Package for the load-adaptive current and stall control block.
// Assumes a single 40 MHz chip clock and a plain parallel register port.
package scsc_pkg;
  localparam logic [6:0]  SMART_CURRENT_CONFIG_ADDR   = 7'h39;
  localparam logic [6:0]  CONSTANT_SPEED_CONTROL_ADDR = 7'h3A;
  localparam logic [31:0] SMART_CURRENT_CONFIG_MASK   = 32'h017F_EF6F;
  localparam logic [31:0] CONSTANT_SPEED_CONTROL_MASK = 32'h00FF_03FF;
  localparam logic [31:0] REG_RESET_VALUE             = 32'h0000_0000;
  localparam int SFILT_POS  = 24;
  localparam int SGT_LSB    = 16;
  localparam int SEIMIN_POS = 15;
  localparam int SEDN_LSB   = 13;
  localparam int SEMAX_LSB  = 8;
  localparam int SEUP_LSB   = 5;
  localparam int SEMIN_LSB  = 0;
  localparam int STALL_ONTIME_LSB = 16;
  localparam int ONTIME_LIMIT_LSB = 0;
  localparam logic [1:0]  STEPS_PER_FILTER = 2'h3;
  localparam logic [9:0]  LOAD_SCALE_SHIFT = 10'h005;
  localparam logic [12:0] STALL_ONTIME_SCALE_SHIFT = 13'h0004;
  localparam logic [12:0] ONTIME_COUNT_MAX = 13'h1FFF;
  localparam logic [5:0]  BLANK_CODE0 = 6'h10;
  localparam logic [5:0]  BLANK_CODE1 = 6'h18;
  localparam logic [5:0]  BLANK_CODE2 = 6'h24;
  localparam logic [5:0]  BLANK_CODE3 = 6'h36;
  localparam logic [5:0]  DOWN_EVERY0 = 6'h20;
  localparam logic [5:0]  DOWN_EVERY1 = 6'h08;
  localparam logic [5:0]  DOWN_EVERY2 = 6'h02;
  localparam logic [5:0]  DOWN_EVERY3 = 6'h01;

  typedef struct packed {
    logic       sfilt;
    logic [6:0] sgt;
    logic       seimin;
    logic [1:0] sedn;
    logic [3:0] semax;
    logic [1:0] seup;
    logic [3:0] semin;
  } scsc_cool_type;

  typedef struct packed {
    logic [7:0] stall_ontime;
    logic [9:0] ontime_limit;
  } scsc_dc_type;
endpackage

// File: design/scsc_top.sv
// Load-adaptive motor current regulation and constant-speed stall control.
// Assumes load values, full-step pulses and PWM on-time come from same-clock logic.
`timescale 1ns/1ps
module scsc_top (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  input  wire logic [9:0]  LOAD_VALUE,
  input  wire logic        LOAD_VALID,
  input  wire logic        FULL_STEP,
  input  wire logic [4:0]  RUN_CURRENT,
  input  wire logic [1:0]  BLANK_SEL,
  input  wire logic        CONST_SPEED,
  input  wire logic        PWM_ON,
  output logic      [9:0]  LOAD_RESULT,
  output logic      [6:0]  STALL_THRESHOLD,
  output logic      [4:0]  ACTUAL_CURRENT,
  output logic      [5:0]  BLANK_CLOCKS,
  output logic             ONTIME_CAP,
  output logic             STEP_LOSS
);
  logic [31:0]           cool_ff;
  logic [31:0]           dc_ff;
  logic [31:0]           rdata_ff;
  scsc_pkg::scsc_cool_type cool;
  scsc_pkg::scsc_dc_type   dc;
  logic [1:0]            fstep_cnt_ff;
  logic [9:0]            load_ff;
  logic                  meas_ff;
  logic [4:0]            cur_ff;
  logic [5:0]            dn_cnt_ff;
  logic [12:0]           on_cnt_ff;
  logic                  cap_ff;
  logic                  loss_ff;
  logic [4:0]            min_cur;
  logic [9:0]            low_thr;
  logic [9:0]            high_thr;
  logic [6:0]            up_sum;
  logic [5:0]            dn_every;
  logic [12:0]           limit_clk;
  logic [12:0]           stall_clk;
  logic [5:0]            blank_clk;

  function automatic logic [5:0] blank_decode(input logic [1:0] code);
    case (code)
      2'h0:    blank_decode = scsc_pkg::BLANK_CODE0;
      2'h1:    blank_decode = scsc_pkg::BLANK_CODE1;
      2'h2:    blank_decode = scsc_pkg::BLANK_CODE2;
      default: blank_decode = scsc_pkg::BLANK_CODE3;
    endcase
  endfunction

  function automatic logic [5:0] down_decode(input logic [1:0] code);
    case (code)
      2'h0:    down_decode = scsc_pkg::DOWN_EVERY0;
      2'h1:    down_decode = scsc_pkg::DOWN_EVERY1;
      2'h2:    down_decode = scsc_pkg::DOWN_EVERY2;
      default: down_decode = scsc_pkg::DOWN_EVERY3;
    endcase
  endfunction

  // Register writes keep only defined field bits.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      cool_ff <= scsc_pkg::REG_RESET_VALUE;
      dc_ff   <= scsc_pkg::REG_RESET_VALUE;
    end else if (REG_WR) begin
      if (REG_ADDR == scsc_pkg::SMART_CURRENT_CONFIG_ADDR) begin
        cool_ff <= REG_WDATA & scsc_pkg::SMART_CURRENT_CONFIG_MASK;
      end
      if (REG_ADDR == scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR) begin
        dc_ff <= REG_WDATA & scsc_pkg::CONSTANT_SPEED_CONTROL_MASK;
      end
    end
  end

  // Read data is registered one cycle after the address; unmapped reads return zero.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rdata_ff <= scsc_pkg::REG_RESET_VALUE;
    end else if (REG_ADDR == scsc_pkg::SMART_CURRENT_CONFIG_ADDR) begin
      rdata_ff <= cool_ff;
    end else if (REG_ADDR == scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR) begin
      rdata_ff <= dc_ff;
    end else begin
      rdata_ff <= scsc_pkg::REG_RESET_VALUE;
    end
  end

  always_comb begin
    cool.sfilt  = cool_ff[scsc_pkg::SFILT_POS];
    cool.sgt    = cool_ff[scsc_pkg::SGT_LSB +: 7];
    cool.seimin = cool_ff[scsc_pkg::SEIMIN_POS];
    cool.sedn   = cool_ff[scsc_pkg::SEDN_LSB +: 2];
    cool.semax  = cool_ff[scsc_pkg::SEMAX_LSB +: 4];
    cool.seup   = cool_ff[scsc_pkg::SEUP_LSB +: 2];
    cool.semin  = cool_ff[scsc_pkg::SEMIN_LSB +: 4];
    dc.stall_ontime = dc_ff[scsc_pkg::STALL_ONTIME_LSB +: 8];
    dc.ontime_limit = dc_ff[scsc_pkg::ONTIME_LIMIT_LSB +: 10];
  end

  // Filtered mode takes the latest load value only on every fourth full step.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      fstep_cnt_ff <= 2'h0;
    end else if (FULL_STEP) begin
      fstep_cnt_ff <= fstep_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      load_ff <= 10'h000;
      meas_ff <= 1'b0;
    end else if (cool.sfilt) begin
      meas_ff <= FULL_STEP && (fstep_cnt_ff == scsc_pkg::STEPS_PER_FILTER);
      if (FULL_STEP && (fstep_cnt_ff == scsc_pkg::STEPS_PER_FILTER)) begin
        load_ff <= LOAD_VALUE;
      end
    end else begin
      meas_ff <= LOAD_VALID;
      if (LOAD_VALID) begin
        load_ff <= LOAD_VALUE;
      end
    end
  end

  always_comb begin
    min_cur   = cool.seimin ? (RUN_CURRENT >> 2) : (RUN_CURRENT >> 1);
    low_thr   = {6'h00, cool.semin} << scsc_pkg::LOAD_SCALE_SHIFT;
    high_thr  = ({6'h00, cool.semin} + {6'h00, cool.semax} + 10'h001)
                << scsc_pkg::LOAD_SCALE_SHIFT;
    up_sum    = {2'h0, cur_ff} + (7'h01 << cool.seup);
    dn_every  = down_decode(cool.sedn);
    blank_clk = blank_decode(BLANK_SEL);
  end

  // Current regulation; a zero low threshold pins the current to the run current.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      cur_ff    <= 5'h00;
      dn_cnt_ff <= 6'h00;
    end else if (cool.semin == 4'h0) begin
      cur_ff    <= RUN_CURRENT;
      dn_cnt_ff <= 6'h00;
    end else if (cur_ff > RUN_CURRENT) begin
      cur_ff <= RUN_CURRENT;
    end else if (cur_ff < min_cur) begin
      cur_ff <= min_cur;
    end else if (meas_ff) begin
      if (load_ff < low_thr) begin
        cur_ff    <= (up_sum > {2'h0, RUN_CURRENT}) ? RUN_CURRENT : up_sum[4:0];
        dn_cnt_ff <= 6'h00;
      end else if (load_ff >= high_thr) begin
        if (dn_cnt_ff + 6'h01 >= dn_every) begin
          dn_cnt_ff <= 6'h00;
          if (cur_ff > min_cur) begin
            cur_ff <= cur_ff - 5'h01;
          end
        end else begin
          dn_cnt_ff <= dn_cnt_ff + 6'h01;
        end
      end
    end
  end

  // The commutation limit never falls below the comparator blank time.
  always_comb begin
    limit_clk = ({3'h0, dc.ontime_limit} > {7'h00, blank_clk}) ?
                {3'h0, dc.ontime_limit} : {7'h00, blank_clk};
    stall_clk = {5'h00, dc.stall_ontime} << scsc_pkg::STALL_ONTIME_SCALE_SHIFT;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      on_cnt_ff <= 13'h0000;
    end else if (!(CONST_SPEED && PWM_ON)) begin
      on_cnt_ff <= 13'h0000;
    end else if (on_cnt_ff != scsc_pkg::ONTIME_COUNT_MAX) begin
      on_cnt_ff <= on_cnt_ff + 13'h0001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      cap_ff  <= 1'b0;
      loss_ff <= 1'b0;
    end else begin
      cap_ff  <= CONST_SPEED && PWM_ON && (on_cnt_ff + 13'h0001 == limit_clk);
      loss_ff <= CONST_SPEED && PWM_ON && (dc.stall_ontime != 8'h00) &&
                 (on_cnt_ff >= stall_clk);
    end
  end

  assign REG_RDATA       = rdata_ff;
  assign LOAD_RESULT     = load_ff;
  assign STALL_THRESHOLD = cool.sgt;
  assign ACTUAL_CURRENT  = cur_ff;
  assign BLANK_CLOCKS    = blank_clk;
  assign ONTIME_CAP      = cap_ff;
  assign STEP_LOSS       = loss_ff;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  a_reserved_zero: assert property (((cool_ff & ~scsc_pkg::SMART_CURRENT_CONFIG_MASK) == 0) &&
      ((dc_ff & ~scsc_pkg::CONSTANT_SPEED_CONTROL_MASK) == 0))
    else $error("Reserved configuration bits are set.");
  a_filter_update: assert property (cool.sfilt && $past(cool.sfilt) && meas_ff |->
      $past(FULL_STEP) && $past(fstep_cnt_ff) == 2'h3)
    else $error("Filtered load update not on fourth full step.");
  a_threshold_out: assert property ($signed(STALL_THRESHOLD) == $signed(cool_ff[22:16]))
    else $error("Stall threshold output does not match register.");
  a_current_floor: assert property (cool.semin != 0 && $stable(RUN_CURRENT) &&
      $stable(cool.seimin) && $past(cur_ff >= min_cur) |-> cur_ff >= min_cur)
    else $error("Current fell below the floor.");
  a_down_one: assert property (cool.semin != 0 && $past(cur_ff) > $past(RUN_CURRENT)
      == 0 && cur_ff < $past(cur_ff) && $stable(RUN_CURRENT) && $past(cur_ff) >= $past(min_cur)
      |-> cur_ff == $past(cur_ff) - 1 && $past(load_ff) >= $past(high_thr))
    else $error("Current dropped without a high load or by more than one.");
  a_up_step: assert property (cool.semin != 0 && meas_ff && load_ff < low_thr &&
      cur_ff >= min_cur && cur_ff <= RUN_CURRENT && $stable(RUN_CURRENT) [*1] ##1
      $stable(RUN_CURRENT) |-> cur_ff > $past(cur_ff) || cur_ff == RUN_CURRENT)
    else $error("Low load did not raise the current.");
  a_disabled_run: assert property (cool.semin == 0 ##1 cool.semin == 0 |->
      ACTUAL_CURRENT == $past(RUN_CURRENT))
    else $error("Disabled control did not follow run current.");
  a_loss_disable: assert property (dc.stall_ontime == 0 && $past(dc.stall_ontime) == 0
      |-> !STEP_LOSS)
    else $error("Step loss flagged with detection disabled.");
  a_loss_time: assert property (CONST_SPEED && PWM_ON && on_cnt_ff >= stall_clk &&
      dc.stall_ontime != 0 |=> STEP_LOSS)
    else $error("Step loss not flagged after stall on-time.");
  a_cap_time: assert property (ONTIME_CAP |-> $past(on_cnt_ff) + 1 == $past(limit_clk)
      && $past(limit_clk) >= {7'h00, $past(blank_clk)})
    else $error("On-time cap at wrong count.");
  a_blank_map: assert property (BLANK_SEL == 2'h3 |-> BLANK_CLOCKS == 6'h36)
    else $error("Blank time code three not 54 clocks.");

  c_current_down: cover property (cool.semin != 0 ##1 cur_ff < $past(cur_ff));
  c_current_up:   cover property (cool.semin != 0 ##1 cur_ff > $past(cur_ff));
  c_step_loss:    cover property ($rose(STEP_LOSS));
  c_ontime_cap:   cover property (ONTIME_CAP);
endmodule

// File: dv/scsc_top_tb.sv
// Self-checking bench for the load-adaptive current and stall control block.
// Assumes the 40 MHz clock and the registered parallel register port of the design.
`timescale 1ns/1ps
module scsc_top_tb;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        reg_wr = 1'b0, load_valid = 1'b0, full_step = 1'b0;
  logic        const_speed = 1'b0, pwm_on = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic [9:0]  load_value = 10'h000, load_result;
  // Run current 20 meets the half floor limit.
  logic [4:0]  run_current = 5'h14, actual_current;
  logic [1:0]  blank_sel = 2'h0;
  logic [6:0]  stall_threshold;
  logic [5:0]  blank_clocks;
  logic        ontime_cap, step_loss;
  integer      error_cnt = 0, num_checks = 0, seed = 30404, cap_n, i, k, cur;
  logic [9:0]  v;
  logic [31:0] rnd;

  scsc_top DUT (.MCLK(mclk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .LOAD_VALUE(load_value),
    .LOAD_VALID(load_valid), .FULL_STEP(full_step), .RUN_CURRENT(run_current),
    .BLANK_SEL(blank_sel), .CONST_SPEED(const_speed), .PWM_ON(pwm_on),
    .LOAD_RESULT(load_result), .STALL_THRESHOLD(stall_threshold),
    .ACTUAL_CURRENT(actual_current), .BLANK_CLOCKS(blank_clocks),
    .ONTIME_CAP(ontime_cap), .STEP_LOSS(step_loss));

  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge mclk) begin reg_addr <= a; reg_wr <= 1'b1; reg_wdata <= d; end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a);
    @(posedge mclk) reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 rd_val = reg_rdata;
  endtask

  function automatic logic [31:0] cfg(input int mn, mx, up, dn, imin, filt);
    return (mn << 0) | (mx << 8) | (up << 5) | (dn << 13) | (imin << 15) | (filt << 24);
  endfunction

  // One measurement; current follows one edge after it is taken.
  task automatic meas(input logic [9:0] val);
    @(posedge mclk) begin load_value <= val; load_valid <= 1'b1; end
    @(posedge mclk) load_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  function automatic logic [9:0] hi_val();
    return 10'd96 + 10'($unsigned($random(seed)) % 928);
  endfunction

  task automatic ontime(input int s, input int exp_cap);
    cap_n = 0;
    @(posedge mclk) pwm_on <= 1'b1;
    for (int n = 1; n <= 60; n++) begin
      @(posedge mclk);
      #1;
      if (ontime_cap === 1'b1 && cap_n == 0) cap_n = n;
      if (s != 0 && n == 16 * s) chk(step_loss, 0);
      if (s != 0 && n == 16 * s + 1) chk(step_loss, 1);
    end
    chk(cap_n, exp_cap);
    if (s == 0) chk(step_loss, 0);
    @(posedge mclk) pwm_on <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    #(25 * 20000);
    error_cnt++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rd(scsc_pkg::SMART_CURRENT_CONFIG_ADDR); chk(rd_val, 32'h0);
    rd(scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR); chk(rd_val, 32'h0);
    wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, 32'hFFFF_FFFF);
    wr(scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR, 32'hFFFF_FFFF);
    wr(7'h3B, 32'hFFFF_FFFF);
    rd(scsc_pkg::SMART_CURRENT_CONFIG_ADDR); chk(rd_val, 32'h017F_EF6F);
    rd(scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR); chk(rd_val, 32'h00FF_03FF);
    rd(7'h3B); chk(rd_val, 32'h0);
    chk(stall_threshold, 7'h40 | 7'h3F);
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, rnd);
      rd(scsc_pkg::SMART_CURRENT_CONFIG_ADDR); chk(rd_val, rnd & 32'h017F_EF6F);
      chk(stall_threshold, rnd[22:16]);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge mclk) blank_sel <= 2'(i);
      @(posedge mclk) #1 chk(blank_clocks, i==0 ? 16 : i==1 ? 24 : i==2 ? 36 : 54);
    end
    // Control off: current tracks run current whatever the load.
    wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, cfg(0, 0, 3, 3, 0, 0));
    meas(10'h000); chk(actual_current, 5'h14);
    chk(load_result, 10'h000);
    wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, cfg(2, 0, 0, 3, 0, 0));
    cur = 20;
    for (i = 0; i < 12; i++) begin
      v = hi_val();
      meas(v);
      chk(load_result, v);
      if (cur > 10) cur--;
      chk(actual_current, cur);
    end
    meas(10'd95); chk(actual_current, 10);
    wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, cfg(2, 0, 0, 3, 1, 0));
    for (i = 0; i < 7; i++) begin
      meas(hi_val());
      if (cur > 5) cur--;
      chk(actual_current, cur);
    end
    for (k = 0; k < 4; k++) begin
      wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, cfg(2, 0, k, 3, 1, 0));
      meas(10'd63);
      cur = (cur + (1 << k) > 20) ? 20 : cur + (1 << k);
      chk(actual_current, cur);
    end
    for (k = 0; k < 3; k++) begin
      wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, cfg(1, 1, 0, k, 0, 0));
      meas(10'd10);
      cur = (cur == 20) ? 20 : cur + 1;
      for (i = 1; i < (k == 0 ? 32 : k == 1 ? 8 : 2); i++) meas(hi_val());
      meas(10'd80);
      chk(actual_current, cur);
      meas(10'd96);
      cur--;
      chk(actual_current, cur);
    end
    wr(scsc_pkg::SMART_CURRENT_CONFIG_ADDR, cfg(0, 0, 0, 0, 0, 1));
    v = load_result;
    meas(10'h2AA); chk(load_result, v);
    for (i = 0; i < 8; i++) begin
      @(posedge mclk) begin load_value <= 10'($random(seed)); full_step <= 1'b1; end
      @(posedge mclk) full_step <= 1'b0;
      if (i % 4 == 3) v = load_value;
      @(posedge mclk) #1 chk(load_result, v);
    end
    @(posedge mclk) begin const_speed <= 1'b1; blank_sel <= 2'h0; end
    // Stall on-time 3 sits just above 40/16, and 40 lies above the 16-clock blank.
    wr(scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR, (3 << 16) | 40);
    ontime(3, 40);
    @(posedge mclk) blank_sel <= 2'h1;
    wr(scsc_pkg::CONSTANT_SPEED_CONTROL_ADDR, 5);
    ontime(0, 24);
    print_verdict;
  end
endmodule
